//--- rtl/bridge_route_map.svh
// Offsets, field positions and reset values for the secondary bridge routing block.
// Assumes byte addressing on a 32-bit Avalon-MM slave; one register per aligned word.
`ifndef BRIDGE_ROUTE_MAP_SVH
`define BRIDGE_ROUTE_MAP_SVH
`define OFS_BRIDGE_CONTROL 8'h3c
`define OFS_BRIDGE_ERROR_COMMAND 8'h40
`define OFS_EVENT_STATUS 8'h44
`define OFS_EVENT_MASK 8'h48
`define OFS_COMMAND 8'h4c
`define BCTL_PARITY_REPORT 0
`define BCTL_ISA_ALIAS 2
`define BCTL_VGA_ROUTE 3
`define BCTL_MONO_PRESENT 4
`define BCTL_MASTER_ABORT_MODE 5
`define BCTL_WMASK 8'h3d
`define ERRCMD_WMASK 8'h01
`define CMD_SYSERR_ENABLE 8
`define CMD_WMASK 16'h0100
`define EVT_PARITY 0
`define EVT_TABORT 1
`define EVT_OTHER 2
`define EVT_ALIAS 3
`define EVT_WIDTH 4
`define RESET_BYTE 8'h00
`endif

//--- rtl/bridge_route_pkg.sv
// Types for the secondary bridge routing block.
// Assumes nothing of its surroundings.
package bridge_route_pkg;
  typedef enum logic [1:0] {
    DEST_HUB = 2'b01,
    DEST_SECONDARY = 2'b10
  } dest_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;
endpackage : bridge_route_pkg

//--- rtl/secondary_bridge_route_error_ctl.sv
// Secondary bridge: CPU I/O and legacy routing, and error-to-message control.
// Assumes the I/O window and the error events come from logic on SYS_CLK; pins are
// synchronised elsewhere. Registers are reached over Avalon-MM with waitrequest.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_route_map.svh"

module secondary_bridge_route_error_ctl (
  input wire logic SYS_CLK, // 250 MHz core clock
  input wire logic RESET, // Synchronous, active high
  input wire logic [7:0] AVS_ADDRESS, // Byte address
  input wire logic AVS_READ, // Read request
  input wire logic AVS_WRITE, // Write request
  input wire logic [31:0] AVS_WRITEDATA, // Write data
  input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes
  output logic [31:0] AVS_READDATA, // Read data
  output logic AVS_WAITREQUEST, // Stall
  input wire logic IO_REQ, // CPU I/O cycle to route
  input wire logic [15:0] IO_ADDR, // CPU I/O address
  input wire logic IO_IN_WINDOW, // Address within window base-limit
  input wire logic MEM_REQ, // CPU memory cycle to route
  input wire logic [31:0] MEM_ADDR, // CPU memory address
  input wire logic MEM_IN_WINDOW, // Address within memory windows
  output logic ROUTE_VALID, // Routing decision pulse
  output logic ROUTE_TO_SECONDARY, // Decision: secondary bus
  output logic ROUTE_TO_HUB, // Decision: hub link
  input wire logic SEC_PARITY_ERR, // Address or data parity error seen
  input wire logic SEC_TARGET_ABORT, // Target abort received
  input wire logic OTHER_ERR, // Other error condition needing a message
  output logic SYSERR_MSG, // Hub-link system-error message pulse
  output logic SEC_PARITY_ERR_PIN_O, // Parity-error pin output
  output logic SEC_PARITY_ERR_PIN_OE, // Parity-error pin enable
  output logic IRQ // Level interrupt
);
  logic [7:0] bctl_reg;
  logic [7:0] errcmd_reg;
  logic [15:0] cmd_reg;
  logic [`EVT_WIDTH-1:0] status_reg;
  logic [`EVT_WIDTH-1:0] mask_reg;
  logic [31:0] rdata_next;
  logic [`EVT_WIDTH-1:0] events;
  logic hit_vga_io;
  logic hit_mda_only;
  logic hit_mda;
  logic hit_vga_mem;
  logic alias_high;
  logic go_secondary;
  logic msg_next;
  logic wr_take;
  logic rd_take;
  bridge_route_pkg::bus_state_t bus_state;
  bridge_route_pkg::dest_t dest_next;

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] val,
                                        input logic en, input logic [7:0] wmask);
    merge8 = en ? ((old & ~wmask) | (val & wmask)) : old;
  endfunction : merge8

  // One wait cycle per access keeps read data registered
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) && (bus_state == bridge_route_pkg::BUS_IDLE);
  assign wr_take = AVS_WRITE && !AVS_WAITREQUEST;
  assign rd_take = AVS_READ && !AVS_WAITREQUEST;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      bus_state <= bridge_route_pkg::BUS_IDLE;
    end else begin
      case (bus_state)
        bridge_route_pkg::BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_state <= bridge_route_pkg::BUS_ANSWER;
          end
        end
        bridge_route_pkg::BUS_ANSWER: begin
          bus_state <= bridge_route_pkg::BUS_IDLE;
        end
        default: begin
          bus_state <= bridge_route_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Write masks keep reserved bits at zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      bctl_reg <= `RESET_BYTE;
      errcmd_reg <= `RESET_BYTE;
      cmd_reg <= 16'h0000;
      mask_reg <= '0;
    end else if (wr_take) begin
      if (AVS_ADDRESS == `OFS_BRIDGE_CONTROL) begin
        bctl_reg <= merge8(bctl_reg, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0], `BCTL_WMASK);
      end
      if (AVS_ADDRESS == `OFS_BRIDGE_ERROR_COMMAND) begin
        errcmd_reg <= merge8(errcmd_reg, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0],
                             `ERRCMD_WMASK);
      end
      if (AVS_ADDRESS == `OFS_COMMAND) begin
        cmd_reg[15:8] <= merge8(cmd_reg[15:8], AVS_WRITEDATA[15:8], AVS_BYTEENABLE[1],
                                8'(`CMD_WMASK >> 8));
      end
      if (AVS_ADDRESS == `OFS_EVENT_MASK && AVS_BYTEENABLE[0]) begin
        mask_reg <= AVS_WRITEDATA[`EVT_WIDTH-1:0];
      end
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (AVS_ADDRESS)
      `OFS_BRIDGE_CONTROL: rdata_next = {24'h00_0000, bctl_reg};
      `OFS_BRIDGE_ERROR_COMMAND: rdata_next = {24'h00_0000, errcmd_reg};
      `OFS_EVENT_STATUS: rdata_next = {28'h000_0000, status_reg};
      `OFS_EVENT_MASK: rdata_next = {28'h000_0000, mask_reg};
      `OFS_COMMAND: rdata_next = {16'h0000, cmd_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && bus_state == bridge_route_pkg::BUS_IDLE) begin
      AVS_READDATA <= rdata_next;
    end
  end

  // Legacy decode: A[15:10] ignored for I/O aliases
  assign hit_vga_io = (IO_ADDR[9:0] >= 10'h3b0 && IO_ADDR[9:0] <= 10'h3bb) ||
                      (IO_ADDR[9:0] >= 10'h3c0 && IO_ADDR[9:0] <= 10'h3df);
  assign hit_mda_only = (IO_ADDR[9:0] == 10'h3bf);
  assign hit_mda = (IO_ADDR[9:0] >= 10'h3b0 && IO_ADDR[9:0] <= 10'h3bf);
  assign hit_vga_mem = (MEM_ADDR >= 32'h000a_0000 && MEM_ADDR <= 32'h000b_ffff);
  assign alias_high = (IO_ADDR[9:8] != 2'b00);

  always_comb begin
    go_secondary = 1'b0;
    if (IO_REQ) begin
      if (bctl_reg[`BCTL_VGA_ROUTE] && hit_vga_io &&
          !(bctl_reg[`BCTL_MONO_PRESENT] && hit_mda)) begin
        go_secondary = 1'b1;
      end else if (bctl_reg[`BCTL_VGA_ROUTE] && (hit_mda || hit_mda_only)) begin
        go_secondary = 1'b0;
      end else if (IO_IN_WINDOW) begin
        go_secondary = !(bctl_reg[`BCTL_ISA_ALIAS] && alias_high);
      end
    end else if (MEM_REQ) begin
      go_secondary = (bctl_reg[`BCTL_VGA_ROUTE] && hit_vga_mem) || MEM_IN_WINDOW;
    end
    dest_next = go_secondary ? bridge_route_pkg::DEST_SECONDARY : bridge_route_pkg::DEST_HUB;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ROUTE_VALID <= 1'b0;
      ROUTE_TO_SECONDARY <= 1'b0;
      ROUTE_TO_HUB <= 1'b0;
    end else begin
      ROUTE_VALID <= IO_REQ | MEM_REQ;
      ROUTE_TO_SECONDARY <= (IO_REQ | MEM_REQ) && dest_next == bridge_route_pkg::DEST_SECONDARY;
      ROUTE_TO_HUB <= (IO_REQ | MEM_REQ) && dest_next == bridge_route_pkg::DEST_HUB;
    end
  end

  always_comb begin
    events = '0;
    events[`EVT_PARITY] = SEC_PARITY_ERR;
    events[`EVT_TABORT] = SEC_TARGET_ABORT;
    events[`EVT_OTHER] = OTHER_ERR;
    events[`EVT_ALIAS] = IO_REQ && IO_IN_WINDOW && bctl_reg[`BCTL_ISA_ALIAS] && alias_high;
  end

  // Secondary message enable taken as the command enable bit
  assign msg_next = cmd_reg[`CMD_SYSERR_ENABLE] && (
                    (SEC_PARITY_ERR && bctl_reg[`BCTL_PARITY_REPORT]) ||
                    (SEC_TARGET_ABORT && errcmd_reg[0]) ||
                    OTHER_ERR);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      SYSERR_MSG <= 1'b0;
    end else begin
      SYSERR_MSG <= msg_next;
    end
  end

  // Set wins over the read clear
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      status_reg <= '0;
    end else if (rd_take && AVS_ADDRESS == `OFS_EVENT_STATUS) begin
      // Clear only what the read returned, so an event in the wait cycle survives
      status_reg <= (status_reg & ~AVS_READDATA[`EVT_WIDTH-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  assign IRQ = |(status_reg & mask_reg);
  assign SEC_PARITY_ERR_PIN_O = 1'b0;
  assign SEC_PARITY_ERR_PIN_OE = 1'b0;

  pty_off_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SEC_PARITY_ERR && !SEC_TARGET_ABORT && !OTHER_ERR && !bctl_reg[`BCTL_PARITY_REPORT])
    |=> !SYSERR_MSG) else $error("parity message while disabled");
  pty_on_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SEC_PARITY_ERR && bctl_reg[`BCTL_PARITY_REPORT] && cmd_reg[`CMD_SYSERR_ENABLE])
    |=> SYSERR_MSG) else $error("parity message missing");
  ta_on_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SEC_TARGET_ABORT && errcmd_reg[0] && cmd_reg[`CMD_SYSERR_ENABLE])
    |=> SYSERR_MSG) else $error("abort message missing");
  ta_off_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SEC_TARGET_ABORT && !SEC_PARITY_ERR && !OTHER_ERR && !errcmd_reg[0])
    |=> !SYSERR_MSG) else $error("abort message while disabled");
  other_err_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (OTHER_ERR && cmd_reg[`CMD_SYSERR_ENABLE]) |=> SYSERR_MSG)
    else $error("other error not reported");
  global_gate_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !cmd_reg[`CMD_SYSERR_ENABLE] |=> !SYSERR_MSG) else $error("message while gated");
  alias_block_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IO_REQ && IO_IN_WINDOW && bctl_reg[`BCTL_ISA_ALIAS] && alias_high && !hit_vga_io)
    |=> ROUTE_TO_HUB && !ROUTE_TO_SECONDARY) else $error("alias sent downstream");
  window_pass_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IO_REQ && IO_IN_WINDOW && !bctl_reg[`BCTL_ISA_ALIAS] && !bctl_reg[`BCTL_VGA_ROUTE])
    |=> ROUTE_TO_SECONDARY) else $error("window address not downstream");
  outside_win_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IO_REQ && !IO_IN_WINDOW && !bctl_reg[`BCTL_VGA_ROUTE]) |=> ROUTE_TO_HUB)
    else $error("outside window went downstream");
  mda_up_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IO_REQ && bctl_reg[`BCTL_VGA_ROUTE] && hit_mda_only) |=> ROUTE_TO_HUB)
    else $error("MDA-only not upstream");
  pin_quiet_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !SEC_PARITY_ERR_PIN_OE) else $error("parity pin driven");
  rsvd_zero_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (bctl_reg & ~`BCTL_WMASK) == 8'h00 && errcmd_reg[7:1] == 7'h00)
    else $error("reserved bits set");
  vga_io_c: cover property (@(posedge SYS_CLK) IO_REQ && hit_vga_io ##1 ROUTE_TO_SECONDARY);
  alias_c: cover property (@(posedge SYS_CLK) events[`EVT_ALIAS] ##1 ROUTE_TO_HUB);
  msg_c: cover property (@(posedge SYS_CLK) SEC_TARGET_ABORT ##1 SYSERR_MSG);
  irq_c: cover property (@(posedge SYS_CLK) IRQ ##[1:10] !IRQ);
  mda_c: cover property (@(posedge SYS_CLK)
    IO_REQ && bctl_reg[`BCTL_VGA_ROUTE] && hit_mda_only ##1 ROUTE_TO_HUB);

  // Routing outputs: one decision per request, always exactly one side
  route_valid_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IO_REQ || MEM_REQ)
    |=> ROUTE_VALID)
    else $error("routing decision missing");

  route_idle_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !(IO_REQ || MEM_REQ)
    |=> !ROUTE_VALID && !ROUTE_TO_SECONDARY && !ROUTE_TO_HUB)
    else $error("routing pulse without request");

  route_onehot_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    ROUTE_VALID
    |-> (ROUTE_TO_SECONDARY ^ ROUTE_TO_HUB))
    else $error("routing not to exactly one side");

  // Legacy ranges
  vga_io_down_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IO_REQ && bctl_reg[`BCTL_VGA_ROUTE] && !bctl_reg[`BCTL_MONO_PRESENT] && hit_vga_io)
    |=> ROUTE_TO_SECONDARY)
    else $error("VGA I/O not downstream");

  vga_mono_down_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IO_REQ && bctl_reg[`BCTL_VGA_ROUTE] && hit_vga_io && !hit_mda)
    |=> ROUTE_TO_SECONDARY)
    else $error("VGA I/O not downstream with mono");

  mono_mda_up_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IO_REQ && bctl_reg[`BCTL_VGA_ROUTE] && bctl_reg[`BCTL_MONO_PRESENT] && hit_mda)
    |=> ROUTE_TO_HUB)
    else $error("MDA reference not upstream");

  mem_up_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (MEM_REQ && !IO_REQ && !bctl_reg[`BCTL_VGA_ROUTE] && !MEM_IN_WINDOW)
    |=> ROUTE_TO_HUB)
    else $error("memory reference not upstream");

  vga_mem_down_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (MEM_REQ && !IO_REQ && bctl_reg[`BCTL_VGA_ROUTE] && hit_vga_mem)
    |=> ROUTE_TO_SECONDARY)
    else $error("VGA memory not downstream");

  // Event status and messages
  alias_event_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IO_REQ && IO_IN_WINDOW && bctl_reg[`BCTL_ISA_ALIAS] && alias_high)
    |=> status_reg[`EVT_ALIAS])
    else $error("diverted cycle not recorded");

  status_sticky_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !(rd_take && AVS_ADDRESS == `OFS_EVENT_STATUS)
    |=> (status_reg & $past(status_reg)) == $past(status_reg))
    else $error("status bit lost without read");

  event_sets_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (|events)
    |=> (status_reg & $past(events)) == $past(events))
    else $error("event not recorded");

  msg_quiet_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !(SEC_PARITY_ERR || SEC_TARGET_ABORT || OTHER_ERR)
    |=> !SYSERR_MSG)
    else $error("message without event");

  pin_low_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !SEC_PARITY_ERR_PIN_O)
    else $error("parity pin value raised");

  // Register bus: one wait cycle, data held until the next read
  wait_release_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST)
    |=> !AVS_WAITREQUEST)
    else $error("second wait cycle");

  readdata_hold_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !(AVS_READ && bus_state == bridge_route_pkg::BUS_IDLE)
    |=> $stable(AVS_READDATA))
    else $error("read data changed without read");

  bctl_rsvd_rd_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (rd_take && AVS_ADDRESS == `OFS_BRIDGE_CONTROL)
    |-> AVS_READDATA[31:6] == 26'h0 && !AVS_READDATA[1])
    else $error("reserved control bits read set");

  unmapped_zero_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (rd_take && AVS_ADDRESS != `OFS_BRIDGE_CONTROL && AVS_ADDRESS != `OFS_BRIDGE_ERROR_COMMAND
     && AVS_ADDRESS != `OFS_EVENT_STATUS && AVS_ADDRESS != `OFS_EVENT_MASK
     && AVS_ADDRESS != `OFS_COMMAND)
    |-> AVS_READDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

  errcmd_write_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_take && AVS_ADDRESS == `OFS_BRIDGE_ERROR_COMMAND && AVS_BYTEENABLE[0])
    |=> errcmd_reg[0] == $past(AVS_WRITEDATA[0]))
    else $error("abort report bit not written");

  bctl_write_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_take && AVS_ADDRESS == `OFS_BRIDGE_CONTROL && AVS_BYTEENABLE[0])
    |=> bctl_reg[`BCTL_ISA_ALIAS] == $past(AVS_WRITEDATA[2]))
    else $error("alias filter bit not written");

  cmd_write_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_take && AVS_ADDRESS == `OFS_COMMAND && AVS_BYTEENABLE[1])
    |=> cmd_reg[`CMD_SYSERR_ENABLE] == $past(AVS_WRITEDATA[8]))
    else $error("global enable not written");

  mask_write_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_take && AVS_ADDRESS == `OFS_EVENT_MASK && AVS_BYTEENABLE[0])
    |=> mask_reg == $past(AVS_WRITEDATA[3:0]))
    else $error("mask not written");
endmodule : secondary_bridge_route_error_ctl
`default_nettype wire

//--- sim/sec_target_model.sv
// Behavioural graphics target on the secondary bus: raises parity errors and aborts.
// Assumes the SYS_CLK domain; the bench commands each event one cycle ahead.
`timescale 1ns/1ps
`default_nettype none
module sec_target_model (
  input wire logic clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic par_cmd, // Request a parity error
  input wire logic abt_cmd, // Request a target abort
  output logic parity_err, // Parity error pulse
  output logic target_abort // Target abort pulse
);
  // One pulse per commanded cycle, never held over
  always_ff @(posedge clk) begin
    parity_err <= !rst && par_cmd;
    target_abort <= !rst && abt_cmd;
  end
endmodule : sec_target_model
`default_nettype wire

//--- sim/test_secondary_bridge_route_error_ctl.sv
// Self-checking bench for the secondary bridge routing and error block.
// Assumes the register map header and the target model; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_route_map.svh"
module test_secondary_bridge_route_error_ctl;
  typedef struct packed {logic [7:0] ctl; logic m; logic [31:0] a; logic w; logic s;} row_t;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic IO_REQ = 1'b0;
  logic MEM_REQ = 1'b0;
  logic win = 1'b0;
  logic [31:0] addr = 32'h0;
  logic ROUTE_VALID, ROUTE_TO_SECONDARY, ROUTE_TO_HUB;
  logic par_cmd = 1'b0;
  logic abt_cmd = 1'b0;
  logic oth_cmd = 1'b0;
  logic OTHER_ERR = 1'b0;
  logic SEC_PARITY_ERR, SEC_TARGET_ABORT, SYSERR_MSG, PIN_O, PIN_OE, IRQ;
  logic [31:0] q;
  int num_errors = 0;
  int n_checks = 0;
  // Control byte, memory flag, address, in window, expect secondary
  row_t rows [15] = '{
    '{8'h00, 1'b0, 32'h0100, 1'b1, 1'b1}, '{8'h04, 1'b0, 32'h0100, 1'b1, 1'b0},
    '{8'h04, 1'b0, 32'h0500, 1'b1, 1'b0}, '{8'h04, 1'b0, 32'h04ff, 1'b1, 1'b1},
    '{8'h04, 1'b0, 32'h0100, 1'b0, 1'b0}, '{8'h00, 1'b0, 32'h03c0, 1'b0, 1'b0},
    '{8'h00, 1'b0, 32'h03bc, 1'b1, 1'b1}, '{8'h08, 1'b0, 32'h03c0, 1'b0, 1'b1},
    '{8'h08, 1'b0, 32'h03b0, 1'b0, 1'b1}, '{8'h08, 1'b0, 32'h03bf, 1'b0, 1'b0},
    '{8'h18, 1'b0, 32'h03b0, 1'b0, 1'b0}, '{8'h18, 1'b0, 32'h07df, 1'b0, 1'b1},
    '{8'h0c, 1'b0, 32'h03c0, 1'b1, 1'b1}, '{8'h08, 1'b1, 32'ha0000, 1'b0, 1'b1},
    '{8'h00, 1'b1, 32'ha0000, 1'b0, 1'b0}};
  always #2 SYS_CLK = ~SYS_CLK;
  // Other errors come from the host side, so the bench stands in for them
  always @(posedge SYS_CLK) OTHER_ERR <= oth_cmd;
  secondary_bridge_route_error_ctl uut (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IO_REQ(IO_REQ), .IO_ADDR(addr[15:0]),
    .IO_IN_WINDOW(win), .MEM_REQ(MEM_REQ), .MEM_ADDR(addr), .MEM_IN_WINDOW(win),
    .ROUTE_VALID(ROUTE_VALID), .ROUTE_TO_SECONDARY(ROUTE_TO_SECONDARY),
    .ROUTE_TO_HUB(ROUTE_TO_HUB), .SEC_PARITY_ERR(SEC_PARITY_ERR),
    .SEC_TARGET_ABORT(SEC_TARGET_ABORT), .OTHER_ERR(OTHER_ERR), .SYSERR_MSG(SYSERR_MSG),
    .SEC_PARITY_ERR_PIN_O(PIN_O), .SEC_PARITY_ERR_PIN_OE(PIN_OE), .IRQ(IRQ));
  sec_target_model partner (.clk(SYS_CLK), .rst(RESET), .par_cmd(par_cmd),
    .abt_cmd(abt_cmd), .parity_err(SEC_PARITY_ERR), .target_abort(SEC_TARGET_ABORT));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge SYS_CLK);
    AVS_READ <= !w;
    AVS_WRITE <= w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    for (i = 0; i < 16; i++) begin
      @(posedge SYS_CLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (i == 16) begin
      num_errors++;
      report_and_stop();
    end
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    // Let the write or read clear settle before anything is compared
    @(posedge SYS_CLK);
  endtask : bus
  task automatic route(input row_t r);
    @(posedge SYS_CLK);
    IO_REQ <= !r.m;
    MEM_REQ <= r.m;
    addr <= r.a;
    win <= r.w;
    @(posedge SYS_CLK);
    IO_REQ <= 1'b0;
    MEM_REQ <= 1'b0;
    @(posedge SYS_CLK);
    chk({ROUTE_VALID, ROUTE_TO_SECONDARY, ROUTE_TO_HUB}, {1'b1, r.s, !r.s});
  endtask : route
  // Event kinds: bit 0 parity, bit 1 target abort, bit 2 other
  task automatic err(input logic [2:0] k, input logic exp);
    @(posedge SYS_CLK);
    {oth_cmd, abt_cmd, par_cmd} <= k;
    @(posedge SYS_CLK);
    {oth_cmd, abt_cmd, par_cmd} <= 3'b000;
    repeat (2) @(posedge SYS_CLK);
    chk(SYSERR_MSG, exp);
  endtask : err
  initial begin
    repeat (5) @(posedge SYS_CLK);
    RESET <= 1'b0;
    bus(1'b0, `OFS_BRIDGE_CONTROL, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `OFS_BRIDGE_ERROR_COMMAND, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, `OFS_BRIDGE_CONTROL, {24'h0, rows[i].ctl});
      route(rows[i]);
    end
    $display("test routing done");
    bus(1'b1, `OFS_BRIDGE_CONTROL, 32'hffffffff);
    bus(1'b0, `OFS_BRIDGE_CONTROL, 32'h0);
    chk(q, 32'h3d);
    bus(1'b1, `OFS_BRIDGE_ERROR_COMMAND, 32'hffffffff);
    bus(1'b0, `OFS_BRIDGE_ERROR_COMMAND, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, 8'h80, 32'hffffffff);
    bus(1'b0, 8'h80, 32'h0);
    chk(q, 32'h0);
    $display("test reserved bits done");
    bus(1'b1, `OFS_BRIDGE_CONTROL, 32'h1);
    bus(1'b1, `OFS_COMMAND, 32'h100);
    bus(1'b1, `OFS_EVENT_MASK, 32'h4);
    err(3'b001, 1'b1);
    err(3'b010, 1'b1);
    chk(IRQ, 1'b0);
    err(3'b100, 1'b1);
    chk(IRQ, 1'b1);
    bus(1'b0, `OFS_EVENT_STATUS, 32'h0);
    chk(q, 32'hf);
    chk(IRQ, 1'b0);
    bus(1'b1, `OFS_BRIDGE_CONTROL, 32'h0);
    bus(1'b1, `OFS_BRIDGE_ERROR_COMMAND, 32'h0);
    err(3'b001, 1'b0);
    err(3'b010, 1'b0);
    err(3'b100, 1'b1);
    bus(1'b1, `OFS_BRIDGE_CONTROL, 32'h1);
    bus(1'b1, `OFS_BRIDGE_ERROR_COMMAND, 32'h1);
    bus(1'b1, `OFS_COMMAND, 32'h0);
    err(3'b111, 1'b0);
    chk(IRQ, 1'b1);
    bus(1'b1, `OFS_EVENT_MASK, 32'h0);
    chk(IRQ, 1'b0);
    bus(1'b0, `OFS_EVENT_STATUS, 32'h0);
    chk(q, 32'h7);
    chk({PIN_O, PIN_OE}, 2'b00);
    $display("test error messages done");
    report_and_stop();
  end
endmodule : test_secondary_bridge_route_error_ctl
`default_nettype wire
